// ==== core/pdc_user_config.sv ====
// Notes on behaviour
// - both config registers are covered by array error detection, except test select
// - registers read and write only in DSI3 mode or PSI5 diagnostic mode
// - filter fast startup restarts only on a 0-to-1 write of the restart bit
// - bypass bit 4 at 0 rate limits the filter, at 1 bypasses it
// - enabled pin: bit 2 at 0 active high pulldown, at 1 active low pullup
// - pin disabled by comm type setting stays high impedance whatever the style
// - bits 7 to 4 of the second register select the self-test function
// - the self-test field never raises an array error
// - codes 0000 normal and 0001 common-mode check fill results by kind
// - codes 0100 to 0111 block processor writes and show fixed patterns
// - kind 00 relative, 01 absolute, 10 filtered absolute, 11 temperature
`timescale 1ns/10ps
`default_nettype none
`include "pdc_params.svh"

module pdc_user_config #(
  parameter int RESULT_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire pdc_pkg::pdc_byte_t reg_addr,
  input wire pdc_pkg::pdc_byte_t reg_wdata,
  output pdc_pkg::pdc_byte_t reg_rdata,
  output logic reg_rd_valid,
  // communication mode
  input wire logic dsi3_mode,
  input wire logic psi5_diag_mode,
  // filter controls
  output logic lowpass_startup_restart,
  output logic rate_limit_bypass,
  // interrupt pin
  input wire logic irq_pin_enable,
  input wire logic irq_condition,
  output logic irq_pin_o,
  output logic irq_pin_oe_n,
  output logic irq_pullup_en,
  output logic irq_pulldown_en,
  // self-test
  output logic cm_verify_en,
  output logic dst_active,
  output logic [1:0] dst_index,
  // signal processor results
  input wire logic sample_valid,
  input wire logic [RESULT_W-1:0] rel_press,
  input wire logic [RESULT_W-1:0] abs_press,
  input wire logic [RESULT_W-1:0] filt_press,
  input wire logic [RESULT_W-1:0] temperature,
  input wire pdc_pkg::pdc_kind_t result_kind_select0,
  input wire pdc_pkg::pdc_kind_t result_kind_select1,
  output logic [RESULT_W-1:0] sensor_result0,
  output logic [RESULT_W-1:0] sensor_result1,
  // array check
  output logic array_error
);
  import pdc_pkg::*;

  if (RESULT_W != 16) begin : g_bad_width
    $error("fixed patterns need a 16-bit result width");
  end

  pdc_byte_t filter_and_irq_pin_config_q;
  pdc_byte_t filter_and_irq_pin_config_d;
  pdc_byte_t selftest_select_config_q;
  pdc_byte_t selftest_select_config_d;
  pdc_byte_t rdata_q;
  pdc_st_code_t st_code;
  pdc_st_mode_t st_mode;
  logic access_ok;
  logic wr_flt;
  logic wr_st;
  logic restart_q;
  logic rd_valid_q;
  logic pin_o_q;
  logic pin_oe_n_q;
  logic pullup_q;
  logic pulldown_q;

  // ****************************************
  // register access
  // ****************************************
  // mode flags come from the protocol logic on this clock, no synchroniser
  assign access_ok = dsi3_mode | psi5_diag_mode;
  assign wr_flt = reg_wr_en && access_ok && reg_addr == `PDC_ADDR_FLT_IRQ;
  assign wr_st = reg_wr_en && access_ok && reg_addr == `PDC_ADDR_ST_SEL;

  // reserved bits are stored as written; software keeps them at zero
  always_comb begin
    filter_and_irq_pin_config_d = filter_and_irq_pin_config_q;
    if (wr_flt) begin
      filter_and_irq_pin_config_d = reg_wdata;
    end
  end

  always_comb begin
    selftest_select_config_d = selftest_select_config_q;
    if (wr_st) begin
      selftest_select_config_d = reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filter_and_irq_pin_config_q <= `PDC_FLT_IRQ_RST;
    end else begin
      filter_and_irq_pin_config_q <= filter_and_irq_pin_config_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      selftest_select_config_q <= `PDC_ST_SEL_RST;
    end else begin
      selftest_select_config_q <= selftest_select_config_d;
    end
  end

  // read answer one cycle later; unmapped or out-of-mode reads return zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= reg_rd_en;
      if (!reg_rd_en) begin
        rdata_q <= rdata_q;
      end else if (!access_ok) begin
        rdata_q <= 8'h00;
      end else if (reg_addr == `PDC_ADDR_FLT_IRQ) begin
        rdata_q <= filter_and_irq_pin_config_q;
      end else if (reg_addr == `PDC_ADDR_ST_SEL) begin
        rdata_q <= selftest_select_config_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rd_valid = rd_valid_q;

  // ****************************************
  // filter controls
  // ****************************************
  // only a rising write edge restarts; rewriting 1 keeps the startup going
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_flt && reg_wdata[`PDC_BIT_RESTART]
        && !filter_and_irq_pin_config_q[`PDC_BIT_RESTART];
    end
  end

  assign lowpass_startup_restart = restart_q;
  assign rate_limit_bypass = filter_and_irq_pin_config_q[`PDC_BIT_RL_BYPASS];

  // ****************************************
  // interrupt pin
  // ****************************************
  // open drain: drive only while asserted, otherwise release onto the pull; a disabled pin is released with both pulls off
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_o_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
      pullup_q <= 1'b0;
      pulldown_q <= 1'b0;
    end else if (!irq_pin_enable) begin
      pin_o_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
      pullup_q <= 1'b0;
      pulldown_q <= 1'b0;
    end else begin
      pin_o_q <= !filter_and_irq_pin_config_q[`PDC_BIT_PIN_STYLE];
      pin_oe_n_q <= !irq_condition;
      pullup_q <= filter_and_irq_pin_config_q[`PDC_BIT_PIN_STYLE];
      pulldown_q <= !filter_and_irq_pin_config_q[`PDC_BIT_PIN_STYLE];
    end
  end

  assign irq_pin_o = pin_o_q;
  assign irq_pin_oe_n = pin_oe_n_q;
  assign irq_pullup_en = pullup_q;
  assign irq_pulldown_en = pulldown_q;

  // ****************************************
  // self-test decode
  // ****************************************
  assign st_code = selftest_select_config_q[`PDC_ST_MSB:`PDC_ST_LSB];
  assign st_mode = pdc_decode_st(st_code);

  // reserved codes fall through to no test at all
  always_comb begin
    cm_verify_en = 1'b0;
    dst_active = 1'b0;
    case (st_mode)
      PDC_MODE_CMV: cm_verify_en = 1'b1;
      PDC_MODE_DST: dst_active = 1'b1;
      default: dst_active = 1'b0;
    endcase
  end

  assign dst_index = dst_active ? st_code[1:0] : 2'h0;

  pdc_result_regs #(
    .RESULT_W(RESULT_W)
  ) u_results (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sample_valid(sample_valid),
    .rel_press(rel_press),
    .abs_press(abs_press),
    .filt_press(filt_press),
    .temperature(temperature),
    .result_kind_select0(result_kind_select0),
    .result_kind_select1(result_kind_select1),
    .selftest_select(st_code),
    .sensor_result0(sensor_result0),
    .sensor_result1(sensor_result1)
  );

  // ****************************************
  // array error detection
  // ****************************************
  // self-test field left out so test changes never flag the array
  pdc_array_check #(
    .CHK_W(12)
  ) u_check (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(wr_flt | wr_st),
    .next_bits({filter_and_irq_pin_config_d, selftest_select_config_d[3:0]}),
    .cur_bits({filter_and_irq_pin_config_q, selftest_select_config_q[3:0]}),
    .array_error(array_error)
  );

  // ****************************************
  // checks
  // ****************************************
  AST_RESTART_RISE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_flt && reg_wdata[7] && !filter_and_irq_pin_config_q[7] |=> lowpass_startup_restart)
    else $error("restart missing after 0-to-1 write");
  AST_RESTART_CAUSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lowpass_startup_restart |-> $past(wr_flt) && $past(reg_wdata[7])
      && !$past(filter_and_irq_pin_config_q[7]))
    else $error("restart without a 0-to-1 write");
  AST_BYPASS_FOLLOWS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_flt |=> rate_limit_bypass == $past(reg_wdata[4]))
    else $error("bypass does not follow written bit");
  AST_NO_WRITE_OUT_OF_MODE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr_en && !dsi3_mode && !psi5_diag_mode |=> $stable(filter_and_irq_pin_config_q)
      && $stable(selftest_select_config_q))
    else $error("write taken outside permitted modes");
  AST_READBACK: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd_en && access_ok && reg_addr == 8'h44 && !wr_st
      |=> reg_rd_valid && reg_rdata == selftest_select_config_q)
    else $error("readback mismatch");
  AST_PIN_HIZ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !irq_pin_enable |=> irq_pin_oe_n && !irq_pullup_en && !irq_pulldown_en)
    else $error("pin not released while disabled");
  AST_PIN_STYLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_pin_enable && irq_condition |=> !irq_pin_oe_n
      && irq_pin_o == !$past(filter_and_irq_pin_config_q[2])
      && irq_pullup_en == $past(filter_and_irq_pin_config_q[2]))
    else $error("pin style wrong");
  AST_CMV_SELECT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_st && reg_wdata[7:4] == 4'h1 |=> cm_verify_en && !dst_active)
    else $error("common-mode check not selected");
  AST_DST_SELECT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_st && reg_wdata[7:6] == 2'h3 |=> dst_active && dst_index == $past(reg_wdata[5:4]))
    else $error("digital self-test not selected");
  AST_ST_NO_ERROR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_st && !array_error |=> ##1 !array_error)
    else $error("self-test write flagged array");
  AST_RDATA_REFUSED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd_en && !access_ok |=> reg_rd_valid && reg_rdata == 8'h00)
    else $error("read answered outside permitted modes");
  AST_PULL_STYLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_pin_enable |=> irq_pulldown_en == !$past(filter_and_irq_pin_config_q[2]))
    else $error("pull current does not follow pin style");
  AST_RESTART_SINGLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lowpass_startup_restart |=> !lowpass_startup_restart)
    else $error("restart pulse longer than one cycle");
  AST_PATTERN_NO_TEST: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_mode == PDC_MODE_PATTERN |-> !cm_verify_en && !dst_active)
    else $error("test function active during fixed pattern");

  COV_RESTART: cover property (@(posedge sys_clk) disable iff (sys_rst)
    lowpass_startup_restart);
  COV_PATTERN: cover property (@(posedge sys_clk) disable iff (sys_rst)
    st_mode == PDC_MODE_PATTERN && st_code[1:0] == 2'h1);
  COV_DST: cover property (@(posedge sys_clk) disable iff (sys_rst)
    dst_active && dst_index == 2'h3);
  COV_PIN_LOW: cover property (@(posedge sys_clk) disable iff (sys_rst)
    !irq_pin_oe_n && !irq_pin_o);
  COV_REFUSED_WRITE: cover property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr_en && !access_ok);

endmodule

`default_nettype wire

// ==== shared/pdc_params.svh ====
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// ****************************************
// register offsets and reset values
// ****************************************
`define PDC_ADDR_FLT_IRQ 8'h43
`define PDC_ADDR_ST_SEL 8'h44
`define PDC_FLT_IRQ_RST 8'h00
`define PDC_ST_SEL_RST 8'h00

// ****************************************
// field positions
// ****************************************
`define PDC_BIT_RESTART 7
`define PDC_BIT_RL_BYPASS 4
`define PDC_BIT_PIN_STYLE 2
`define PDC_ST_MSB 7
`define PDC_ST_LSB 4

// ****************************************
// self-test codes and fixed patterns
// ****************************************
`define PDC_ST_NORMAL 4'h0
`define PDC_ST_CMV 4'h1
`define PDC_ST_PAT_HI 2'h1
`define PDC_ST_DST_HI 2'h3
`define PDC_PAT_0 16'h0000
`define PDC_PAT_1 16'hAAAA
`define PDC_PAT_2 16'h5555
`define PDC_PAT_3 16'hFFFF

// ****************************************
// result kinds
// ****************************************
`define PDC_KIND_REL 2'h0
`define PDC_KIND_ABS 2'h1
`define PDC_KIND_FILT 2'h2
`define PDC_KIND_TEMP 2'h3

`endif

// ==== shared/pdc_pkg.sv ====
`include "pdc_params.svh"

package pdc_pkg;

  typedef logic [7:0] pdc_byte_t;
  typedef logic [1:0] pdc_kind_t;
  typedef logic [3:0] pdc_st_code_t;

  typedef enum {
    PDC_MODE_NORMAL,
    PDC_MODE_CMV,
    PDC_MODE_PATTERN,
    PDC_MODE_DST,
    PDC_MODE_RSVD
  } pdc_st_mode_t;

  function automatic pdc_st_mode_t pdc_decode_st(input pdc_st_code_t code);
    pdc_st_mode_t m;
    m = PDC_MODE_RSVD;
    if (code == `PDC_ST_NORMAL) begin
      m = PDC_MODE_NORMAL;
    end else if (code == `PDC_ST_CMV) begin
      m = PDC_MODE_CMV;
    end else if (code[3:2] == `PDC_ST_PAT_HI) begin
      m = PDC_MODE_PATTERN;
    end else if (code[3:2] == `PDC_ST_DST_HI) begin
      m = PDC_MODE_DST;
    end
    return m;
  endfunction

endpackage

// ==== core/pdc_array_check.sv ====
`timescale 1ns/10ps
`default_nettype none

module pdc_array_check #(
  parameter int CHK_W = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // protected contents
  input wire logic load,
  input wire logic [CHK_W-1:0] next_bits,
  input wire logic [CHK_W-1:0] cur_bits,
  // status
  output logic array_error
);
  import pdc_pkg::*;

  logic parity_q;
  logic error_q;
  logic mismatch;

  // ****************************************
  // stored check bit
  // ****************************************
  // parity is taken from the value being written, so it lands with the data
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      parity_q <= 1'b0;
    end else if (load) begin
      parity_q <= ^next_bits;
    end
  end

  assign mismatch = (^cur_bits) != parity_q;

  // sticky until reset; a corrupted array stays flagged
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      error_q <= 1'b0;
    end else if (mismatch) begin
      error_q <= 1'b1;
    end
  end

  assign array_error = error_q;

  AST_ERR_CAUSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(error_q) |-> $past(mismatch))
    else $error("array error raised without a mismatch");
  AST_WRITE_CLEAN: assert property (@(posedge sys_clk) disable iff (sys_rst)
    load && !error_q |=> !mismatch)
    else $error("a legal write produced a check mismatch");

endmodule

`default_nettype wire

// ==== core/pdc_result_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pdc_params.svh"

module pdc_result_regs #(
  parameter int RESULT_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // signal processor sources
  input wire logic sample_valid,
  input wire logic [RESULT_W-1:0] rel_press,
  input wire logic [RESULT_W-1:0] abs_press,
  input wire logic [RESULT_W-1:0] filt_press,
  input wire logic [RESULT_W-1:0] temperature,
  // selection
  input wire pdc_pkg::pdc_kind_t result_kind_select0,
  input wire pdc_pkg::pdc_kind_t result_kind_select1,
  input wire pdc_pkg::pdc_st_code_t selftest_select,
  // results
  output logic [RESULT_W-1:0] sensor_result0,
  output logic [RESULT_W-1:0] sensor_result1
);
  import pdc_pkg::*;

  // the fixed test patterns are 16 bits wide
  if (RESULT_W != 16) begin : g_bad_width
    $error("result width must be 16 bits");
  end

  pdc_st_mode_t mode;
  logic [RESULT_W-1:0] pattern;
  logic [RESULT_W-1:0] res_q [2];
  pdc_kind_t kind [2];

  assign mode = pdc_decode_st(selftest_select);
  assign kind[0] = result_kind_select0;
  assign kind[1] = result_kind_select1;

  always_comb begin
    case (selftest_select[1:0])
      2'h0: pattern = `PDC_PAT_0;
      2'h1: pattern = `PDC_PAT_1;
      2'h2: pattern = `PDC_PAT_2;
      default: pattern = `PDC_PAT_3;
    endcase
  end

  // ****************************************
  // per-channel result registers
  // ****************************************
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [RESULT_W-1:0] src;
    always_comb begin
      case (kind[ch])
        `PDC_KIND_REL: src = rel_press;
        `PDC_KIND_ABS: src = abs_press;
        `PDC_KIND_FILT: src = filt_press;
        default: src = temperature;
      endcase
    end
    // pattern modes hold off the processor; digital tests leave results alone
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        res_q[ch] <= '0;
      end else if (mode == PDC_MODE_PATTERN) begin
        res_q[ch] <= pattern;
      end else if (sample_valid && (mode == PDC_MODE_NORMAL || mode == PDC_MODE_CMV)) begin
        res_q[ch] <= src;
      end
    end
  end

  assign sensor_result0 = res_q[0];
  assign sensor_result1 = res_q[1];

  AST_PATTERN_HELD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode == PDC_MODE_PATTERN |=> sensor_result0 == $past(pattern)
      && sensor_result1 == $past(pattern))
    else $error("fixed pattern not shown in result registers");
  AST_KIND_FILL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sample_valid && mode == PDC_MODE_NORMAL && kind[0] == `PDC_KIND_ABS
      |=> sensor_result0 == $past(abs_press))
    else $error("result kind not honoured");
  AST_CMV_FILL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sample_valid && mode == PDC_MODE_CMV && kind[1] == `PDC_KIND_TEMP
      |=> sensor_result1 == $past(temperature))
    else $error("result not filled in common-mode verification");

endmodule

`default_nettype wire

// ==== bench/pdc_user_config_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pdc_params.svh"

module pdc_user_config_tb;
  import pdc_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  pdc_byte_t reg_addr = 8'h00;
  pdc_byte_t reg_wdata = 8'h00;
  logic dsi3_mode = 1'b1;
  logic psi5_diag_mode = 1'b0;
  logic irq_pin_enable = 1'b0;
  logic irq_condition = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] v [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  pdc_kind_t result_kind_select0 = 2'h0;
  pdc_kind_t result_kind_select1 = 2'h0;
  pdc_byte_t reg_rdata;
  logic reg_rd_valid, lowpass_startup_restart, rate_limit_bypass;
  logic irq_pin_o, irq_pin_oe_n, irq_pullup_en, irq_pulldown_en;
  logic cm_verify_en, dst_active, array_error;
  logic [1:0] dst_index;
  logic [15:0] sensor_result0, sensor_result1;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'hb161;
  pdc_byte_t m43 = 8'h00;
  pdc_byte_t m44 = 8'h00;
  pdc_byte_t d1, d2;
  pdc_byte_t rd_q [$];
  bit rs_q [$];
  logic [15:0] e0 = 16'h0000;
  logic [15:0] e1 = 16'h0000;

  always #25 sys_clk = ~sys_clk;

  pdc_user_config dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .dsi3_mode(dsi3_mode), .psi5_diag_mode(psi5_diag_mode),
    .lowpass_startup_restart(lowpass_startup_restart),
    .rate_limit_bypass(rate_limit_bypass),
    .irq_pin_enable(irq_pin_enable), .irq_condition(irq_condition),
    .irq_pin_o(irq_pin_o), .irq_pin_oe_n(irq_pin_oe_n),
    .irq_pullup_en(irq_pullup_en), .irq_pulldown_en(irq_pulldown_en),
    .cm_verify_en(cm_verify_en), .dst_active(dst_active), .dst_index(dst_index),
    .sample_valid(sample_valid), .rel_press(v[0]), .abs_press(v[1]),
    .filt_press(v[2]), .temperature(v[3]),
    .result_kind_select0(result_kind_select0), .result_kind_select1(result_kind_select1),
    .sensor_result0(sensor_result0), .sensor_result1(sensor_result1),
    .array_error(array_error)
  );

  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // result watchers: oldest note against each answer
  // ****************************************
  always @(posedge sys_clk) begin
    if (!sys_rst && reg_rd_valid === 1'b1) begin
      if (rd_q.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_word({8'h00, reg_rdata}, {8'h00, rd_q.pop_front()});
    end
    if (!sys_rst && lowpass_startup_restart === 1'b1) begin
      if (rs_q.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_bit(1'b1, rs_q.pop_front());
    end
  end

  // ****************************************
  // register port driver
  // ****************************************
  // strobes stay up between calls so that accesses can run back to back
  task automatic wr(input pdc_byte_t a, input pdc_byte_t d);
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    if ((dsi3_mode | psi5_diag_mode) && a == `PDC_ADDR_FLT_IRQ) begin
      if (d[`PDC_BIT_RESTART] && !m43[`PDC_BIT_RESTART]) rs_q.push_back(1'b1);
      m43 = d;
    end
    if ((dsi3_mode | psi5_diag_mode) && a == `PDC_ADDR_ST_SEL) m44 = d;
  endtask

  task automatic rd(input pdc_byte_t a);
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    if (!(dsi3_mode | psi5_diag_mode)) rd_q.push_back(8'h00);
    else if (a == `PDC_ADDR_FLT_IRQ) rd_q.push_back(m43);
    else if (a == `PDC_ADDR_ST_SEL) rd_q.push_back(m44);
    else rd_q.push_back(8'h00);
  endtask

  task automatic idle(input int n);
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    sample_valid <= 1'b0;
    repeat (n - 1) @(posedge sys_clk);
  endtask

  task automatic end_test(input string name);
    idle(2);
    for (int i = 0; i < 20 && (rd_q.size() + rs_q.size()) != 0; i++) @(posedge sys_clk);
    if ((rd_q.size() + rs_q.size()) != 0) begin
      chk_bit(1'b1, 1'b0);
      give_verdict();
    end
    chk_bit(array_error, 1'b0);
    $display("test %s done", name);
  endtask

  function automatic logic [15:0] pat(input logic [1:0] i);
    case (i)
      2'h0: return `PDC_PAT_0;
      2'h1: return `PDC_PAT_1;
      2'h2: return `PDC_PAT_2;
      default: return `PDC_PAT_3;
    endcase
  endfunction

  initial begin
    repeat (60000) @(posedge sys_clk);
    chk_bit(1'b1, 1'b0);
    give_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h43);
    rd(8'h44);
    rd(8'h45);
    end_test("reset values");
    dsi3_mode <= 1'b0;
    wr(8'h43, 8'h10);
    rd(8'h43);
    idle(2);
    @(negedge sys_clk);
    chk_bit(rate_limit_bypass, 1'b0);
    idle(1);
    psi5_diag_mode <= 1'b1;
    rd(8'h43);
    wr(8'h43, 8'h10);
    rd(8'h43);
    idle(1);
    psi5_diag_mode <= 1'b0;
    dsi3_mode <= 1'b1;
    wr(8'h43, 8'h00);
    rd(8'h43);
    rd(8'h42);
    end_test("access modes");
    wr(8'h43, 8'h00);
    wr(8'h43, 8'h80);
    wr(8'h43, 8'h80);
    wr(8'h43, 8'h00);
    wr(8'h43, 8'h80);
    end_test("restart edge");
    for (int i = 0; i < 16; i++) begin
      d1 = 8'($random(seed)) & 8'h94;
      d2 = 8'($random(seed)) & 8'h94;
      wr(8'h43, d1);
      if (i[0]) wr(8'h43, d2);
      idle(2);
      @(negedge sys_clk);
      chk_bit(rate_limit_bypass, m43[`PDC_BIT_RL_BYPASS]);
      rd(8'h43);
    end
    end_test("random filter writes");
    for (int i = 0; i < 8; i++) begin
      wr(8'h43, {5'h00, i[1], 2'h0});
      irq_pin_enable <= i[2];
      irq_condition <= i[0];
      idle(3);
      @(negedge sys_clk);
      chk_bit(irq_pin_oe_n, !(i[2] && i[0]));
      chk_bit(irq_pullup_en, i[2] && i[1]);
      chk_bit(irq_pulldown_en, i[2] && !i[1]);
      if (i[2] && i[0]) chk_bit(irq_pin_o, !i[1]);
    end
    end_test("interrupt pin");
    for (int c = 0; c < 16; c++) begin
      // reserved codes are left out as software must not write them
      if (c == 2 || c == 3 || c[3:2] == 2'h2) continue;
      wr(8'h44, {c[3:0], 4'h0});
      for (int k = 0; k < 4; k++) begin
        @(posedge sys_clk);
        for (int s = 0; s < 4; s++) v[s] <= 16'($random(seed));
        reg_wr_en <= 1'b0;
        sample_valid <= 1'b1;
        result_kind_select0 <= k[1:0];
        result_kind_select1 <= ~k[1:0];
        idle(1);
        @(negedge sys_clk);
        if (c < 2) begin
          e0 = v[k[1:0]];
          e1 = v[~k[1:0]];
        end else if (c[3:2] == 2'h1) begin
          e0 = pat(c[1:0]);
          e1 = pat(c[1:0]);
        end
        chk_word(sensor_result0, e0);
        chk_word(sensor_result1, e1);
      end
      chk_bit(cm_verify_en, c == 1);
      chk_bit(dst_active, c[3:2] == 2'h3);
      chk_word({14'h0000, dst_index}, (c[3:2] == 2'h3) ? c[1:0] : 16'h0000);
      rd(8'h44);
    end
    end_test("self-test codes");
    idle(1);
    sys_rst <= 1'b1;
    irq_pin_enable <= 1'b0;
    idle(2);
    sys_rst <= 1'b0;
    m43 = 8'h00;
    m44 = 8'h00;
    rd(8'h43);
    rd(8'h44);
    idle(1);
    @(negedge sys_clk);
    chk_word(sensor_result0, 16'h0000);
    chk_bit(irq_pin_oe_n, 1'b1);
    end_test("second reset");
    give_verdict();
  end
endmodule
`default_nettype wire
